/* File: emb_bus_ctrl.sv */
// external program and data memory bus control with latch strobe quieting
`timescale 1ns/1ps
`include "emb_defines.svh"

module emb_bus_ctrl (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic externalCodeSelect,
    input wire logic idleMode,
    input wire logic powerDownMode,
    input wire logic powerCtrlWrEn,
    input wire logic [7:0] powerCtrlWrData,
    input wire logic [15:0] fetchAddr,
    input wire logic dataReq,
    input wire emb_pkg::emb_data_req_t dataCmd,
    input wire logic [7:0] lowPortReg,
    input wire logic [7:0] upperPortReg,
    input wire logic [7:0] lowBusPortIn,
    output emb_pkg::emb_pin_t lowBusPort,
    output logic [7:0] upperAddressPort,
    output logic addrLatchStrobe,
    output logic programFetchStrobeN,
    output logic writeStrobeN,
    output logic readStrobeN,
    output logic latchQuietBit,
    output logic fetchValid,
    output logic [7:0] fetchData,
    output logic dataAck,
    output logic [7:0] dataRdata
);

    logic [3:0] phase;
    logic [2:0] sub;
    logic [15:0] curAddr;
    logic extSlot;
    logic asleep;

    logic latchQuiet_ff, nxt_latchQuiet;
    logic codeSelLatched_ff, nxt_codeSelLatched;
    logic codeSelCaught_ff, nxt_codeSelCaught;
    emb_pkg::emb_cycle_kind_t cycle_ff, nxt_cycle;
    emb_pkg::emb_data_req_t cmd_ff, nxt_cmd;
    logic [15:0] slotAddr_ff, nxt_slotAddr;

    emb_pkg::emb_pin_t lowBus_ff, nxt_lowBus;
    logic [7:0] upper_ff, nxt_upper;
    logic ale_ff, nxt_ale;
    logic fetchStbN_ff, nxt_fetchStbN;
    logic wrN_ff, nxt_wrN;
    logic rdN_ff, nxt_rdN;
    logic fetchValid_ff, nxt_fetchValid;
    logic [7:0] fetchData_ff, nxt_fetchData;
    logic dataAck_ff, nxt_dataAck;
    logic [7:0] dataRdata_ff, nxt_dataRdata;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // position within the half machine cycle
    function automatic logic [2:0] subPhase(input logic [3:0] p);
        logic [3:0] s;
        s = (p >= `EMB_HALF) ? p - `EMB_HALF : p;
        return s[2:0];
    endfunction : subPhase

    // a fetch leaves the chip when external code was chosen or past internal ROM
    function automatic logic isExternal(input logic [15:0] a, input logic intSel);
        return !intSel || (a >= `EMB_INT_ROM_LIMIT);
    endfunction : isExternal

    emb_cycle_timer u_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .phase(phase)
    );

    always_comb begin
        sub = subPhase(phase);
        curAddr = (sub == 3'h0) ? fetchAddr : slotAddr_ff;
        // before the capture edge the strap itself decides, so no stray external slot
        extSlot = isExternal(curAddr, nxt_codeSelLatched);
        asleep = idleMode || powerDownMode;
    end

    // control state: quiet bit, code source capture, cycle kind
    always_comb begin
        nxt_latchQuiet = powerCtrlWrEn ? powerCtrlWrData[`EMB_QUIET_BIT]
                                       : latchQuiet_ff;
        // a strap cannot load under async reset, so it is caught on the first edge after
        nxt_codeSelCaught = 1'b1;
        nxt_codeSelLatched = codeSelCaught_ff ? codeSelLatched_ff
                                              : externalCodeSelect;
        nxt_slotAddr = (sub == 3'h0) ? fetchAddr : slotAddr_ff;
        nxt_cycle = cycle_ff;
        nxt_cmd = cmd_ff;
        if (phase == `EMB_DATA_ACCEPT) begin
            // no back-to-back data cycles: a data cycle is always followed by a fetch cycle
            if (dataReq && !asleep && cycle_ff != emb_pkg::EMB_DATA_CYCLE) begin
                nxt_cycle = emb_pkg::EMB_DATA_CYCLE;
                nxt_cmd = dataCmd;
            end else begin
                nxt_cycle = emb_pkg::EMB_FETCH_CYCLE;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            latchQuiet_ff <= `EMB_QUIET_RESET;
            codeSelCaught_ff <= 1'b0;
            codeSelLatched_ff <= 1'b0;
            slotAddr_ff <= 16'h0000;
            cycle_ff <= emb_pkg::EMB_FETCH_CYCLE;
            cmd_ff <= '0;
        end else begin
            latchQuiet_ff <= nxt_latchQuiet;
            codeSelCaught_ff <= nxt_codeSelCaught;
            codeSelLatched_ff <= nxt_codeSelLatched;
            slotAddr_ff <= nxt_slotAddr;
            cycle_ff <= nxt_cycle;
            cmd_ff <= nxt_cmd;
        end
    end

    // pin state: every pin is registered, so pins lag the phase by one clock
    always_comb begin
        nxt_ale = 1'b0;
        nxt_fetchStbN = 1'b1;
        nxt_wrN = 1'b1;
        nxt_rdN = 1'b1;
        nxt_upper = upperPortReg;
        nxt_lowBus.out = `EMB_PORT_ALL_ZERO;
        nxt_lowBus.oeN = lowPortReg;
        nxt_fetchValid = 1'b0;
        nxt_fetchData = fetchData_ff;
        nxt_dataAck = 1'b0;
        nxt_dataRdata = dataRdata_ff;
        unique case (cycle_ff)
            emb_pkg::EMB_DATA_CYCLE: begin
                // first pulse carries the data address, second is dropped
                nxt_ale = (phase <= `EMB_DATA_ALE_END);
                nxt_upper = cmd_ff.wide ? cmd_ff.addr[15:8] : upperPortReg;
                nxt_lowBus.oeN = `EMB_PORT_ALL_ONES;
                if (phase <= `EMB_DATA_ADDR_END) begin
                    nxt_lowBus.out = cmd_ff.addr[7:0];
                    nxt_lowBus.oeN = `EMB_PORT_ALL_ZERO;
                end else if (cmd_ff.write && phase >= `EMB_DATA_WR_FIRST
                             && phase <= `EMB_DATA_WR_LAST) begin
                    nxt_lowBus.out = cmd_ff.wdata;
                    nxt_lowBus.oeN = `EMB_PORT_ALL_ZERO;
                end
                if (phase >= `EMB_DATA_STB_FIRST && phase <= `EMB_DATA_STB_LAST) begin
                    nxt_wrN = !cmd_ff.write;
                    nxt_rdN = cmd_ff.write;
                end
                if (!cmd_ff.write && phase == `EMB_DATA_SAMPLE) begin
                    nxt_dataRdata = lowBusPortIn;
                end
                nxt_dataAck = (phase == `EMB_DATA_SAMPLE);
                // fetch strobe stays idle for the whole cycle
            end
            emb_pkg::EMB_FETCH_CYCLE: begin
                if (!asleep) begin
                    // quiet only holds for internal fetches below the ROM limit
                    nxt_ale = (sub <= `EMB_SLOT_ALE_END)
                              && (!latchQuiet_ff || extSlot);
                    if (extSlot) begin
                        nxt_upper = curAddr[15:8];
                        nxt_lowBus.oeN = `EMB_PORT_ALL_ONES;
                        if (sub <= `EMB_SLOT_ADDR_END) begin
                            nxt_lowBus.out = curAddr[7:0];
                            nxt_lowBus.oeN = `EMB_PORT_ALL_ZERO;
                        end
                        nxt_fetchStbN = !(sub >= `EMB_SLOT_FETCH_FIRST
                                      && sub <= `EMB_SLOT_FETCH_LAST);
                        if (sub == `EMB_SLOT_SAMPLE) begin
                            nxt_fetchValid = 1'b1;
                            nxt_fetchData = lowBusPortIn;
                        end
                    end
                end
            end
        endcase
        // sleep levels override the schedule while quiet
        if (latchQuiet_ff && idleMode) begin
            nxt_ale = 1'b1;
        end else if (latchQuiet_ff && powerDownMode) begin
            nxt_ale = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ale_ff <= 1'b0;
            fetchStbN_ff <= 1'b1;
            wrN_ff <= 1'b1;
            rdN_ff <= 1'b1;
            upper_ff <= `EMB_PORT_ALL_ONES;
            lowBus_ff.out <= `EMB_PORT_ALL_ZERO;
            lowBus_ff.oeN <= `EMB_PORT_ALL_ONES;
            fetchValid_ff <= 1'b0;
            fetchData_ff <= 8'h00;
            dataAck_ff <= 1'b0;
            dataRdata_ff <= 8'h00;
        end else begin
            ale_ff <= nxt_ale;
            fetchStbN_ff <= nxt_fetchStbN;
            wrN_ff <= nxt_wrN;
            rdN_ff <= nxt_rdN;
            upper_ff <= nxt_upper;
            lowBus_ff <= nxt_lowBus;
            fetchValid_ff <= nxt_fetchValid;
            fetchData_ff <= nxt_fetchData;
            dataAck_ff <= nxt_dataAck;
            dataRdata_ff <= nxt_dataRdata;
        end
    end

    assign addrLatchStrobe = ale_ff;
    assign programFetchStrobeN = fetchStbN_ff;
    assign writeStrobeN = wrN_ff;
    assign readStrobeN = rdN_ff;
    assign upperAddressPort = upper_ff;
    assign lowBusPort = lowBus_ff;
    assign latchQuietBit = latchQuiet_ff;
    assign fetchValid = fetchValid_ff;
    assign fetchData = fetchData_ff;
    assign dataAck = dataAck_ff;
    assign dataRdata = dataRdata_ff;

    a_ale_normal_rate: assert property (
        (sub == 3'h0 && cycle_ff == emb_pkg::EMB_FETCH_CYCLE && !latchQuiet_ff && !asleep)
        |=> ale_ff ##1 ale_ff ##1 !ale_ff [*4])
        else $error("latch strobe not a two-high four-low pulse per slot");

    a_data_ale_skip: assert property (
        (cycle_ff == emb_pkg::EMB_DATA_CYCLE && phase == `EMB_HALF && !asleep)
        |=> !ale_ff [*6])
        else $error("second latch strobe of a data cycle not dropped");

    a_quiet_ale_low: assert property (
        (latchQuiet_ff && cycle_ff == emb_pkg::EMB_FETCH_CYCLE && !extSlot && !asleep)
        |=> !ale_ff)
        else $error("latch strobe toggled while quiet on internal fetch");

    a_quiet_reset_write: assert property (
        powerCtrlWrEn |=> (latchQuietBit == $past(powerCtrlWrData[`EMB_QUIET_BIT])))
        else $error("quiet bit did not follow the control write");

    a_data_ale_strobe: assert property (
        (cycle_ff == emb_pkg::EMB_DATA_CYCLE && phase == 4'h0 && !asleep)
        |=> ale_ff ##1 ale_ff ##1 !ale_ff ##2 (!writeStrobeN || !readStrobeN))
        else $error("data cycle latch pulse or strobe order wrong");

    a_quiet_sleep_level: assert property (
        (latchQuiet_ff && (idleMode || powerDownMode)) |=> (ale_ff == $past(idleMode)))
        else $error("quiet sleep level of latch strobe wrong");

    a_fetch_strobe_twice: assert property (
        (cycle_ff == emb_pkg::EMB_FETCH_CYCLE && extSlot && !asleep && sub == `EMB_SLOT_ADDR_END)
        |=> fetchStbN_ff ##1 !fetchStbN_ff [*2] ##1 fetchStbN_ff)
        else $error("fetch strobe not two cycles per external slot");

    a_data_no_fetch: assert property (
        (cycle_ff == emb_pkg::EMB_DATA_CYCLE) |=> fetchStbN_ff)
        else $error("fetch strobe active in data cycle");

    a_internal_no_fetch: assert property (
        (cycle_ff == emb_pkg::EMB_FETCH_CYCLE && !extSlot) |=> (fetchStbN_ff && !fetchValid_ff))
        else $error("fetch strobe active on internal fetch");

    a_upper_port_src: assert property (
        (cycle_ff == emb_pkg::EMB_DATA_CYCLE && !cmd_ff.wide)
        |=> (upperAddressPort == $past(upperPortReg)))
        else $error("upper port not register contents on narrow access");

    a_code_select_held: assert property (
        codeSelCaught_ff |=> $stable(codeSelLatched_ff))
        else $error("code source changed after reset");

endmodule : emb_bus_ctrl

/* File: emb_cycle_timer.sv */
// machine cycle phase counter running on the oscillator clock
`timescale 1ns/1ps
`include "emb_defines.svh"

module emb_cycle_timer (
    input wire logic sys_clk,
    input wire logic reset,
    output logic [3:0] phase
);

    logic [3:0] phase_ff;
    logic [3:0] nxt_phase;

    always_comb begin
        nxt_phase = (phase_ff == `EMB_PHASE_LAST) ? 4'h0 : phase_ff + 4'h1;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase_ff <= 4'h0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign phase = phase_ff;

endmodule : emb_cycle_timer

/* File: emb_defines.svh */
// timing, field and address constants of the external memory bus controller
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH

// machine cycle of twelve oscillator periods, two address slots of six each
`define EMB_PHASE_LAST 4'hb
`define EMB_HALF 4'h6

// fetch slot, phases counted within the half machine cycle
`define EMB_SLOT_ALE_END 3'h1
`define EMB_SLOT_ADDR_END 3'h2
`define EMB_SLOT_FETCH_FIRST 3'h3
`define EMB_SLOT_FETCH_LAST 3'h4
`define EMB_SLOT_SAMPLE 3'h5

// data cycle, phases counted within the whole machine cycle
`define EMB_DATA_ALE_END 4'h1
`define EMB_DATA_ADDR_END 4'h2
`define EMB_DATA_WR_FIRST 4'h3
`define EMB_DATA_WR_LAST 4'ha
`define EMB_DATA_STB_FIRST 4'h4
`define EMB_DATA_STB_LAST 4'h9
`define EMB_DATA_SAMPLE 4'ha
`define EMB_DATA_ACCEPT 4'hb

// internal code space ends at 16384, external space reaches 64k
`define EMB_INT_ROM_LIMIT 16'h4000

// power control register
`define EMB_QUIET_BIT 5
`define EMB_QUIET_RESET 1'h0

// port reset levels
`define EMB_PORT_ALL_ONES 8'hff
`define EMB_PORT_ALL_ZERO 8'h00

`endif

/* File: emb_mem_model.sv */
// behavioural external memory and address latch on the multiplexed bus
`timescale 1ns/1ps
module emb_mem_model (
    input wire logic sys_clk,
    input wire emb_pkg::emb_pin_t lowBusPort,
    input wire logic [7:0] upperAddressPort,
    input wire logic addrLatchStrobe,
    input wire logic programFetchStrobeN,
    input wire logic writeStrobeN,
    input wire logic readStrobeN,
    output logic [7:0] lowBusPortIn
);
    logic [7:0] mem [0:65535];
    logic [7:0] latchLo = 8'h00;
    logic [7:0] lastLevel = 8'h00;
    logic wrArmed = 1'b0;
    logic [15:0] memAddr;
    logic memDrive;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
        end
    end
    assign memAddr = {upperAddressPort, latchLo};
    assign memDrive = (programFetchStrobeN === 1'b0) || (readStrobeN === 1'b0);
    // no pull-up on this port: a released bit shows a level that flips every cycle
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (lowBusPort.oeN[b] === 1'b0) begin
                lowBusPortIn[b] = lowBusPort.out[b];
            end else if (memDrive) begin
                lowBusPortIn[b] = mem[memAddr][b];
            end else begin
                lowBusPortIn[b] = !lastLevel[b];
            end
        end
    end
    always @(posedge sys_clk) lastLevel <= lowBusPortIn;
    // latch closes on the falling strobe, keeping the low address byte
    always @(negedge addrLatchStrobe) latchLo <= lowBusPortIn;
    // write only on a rise that follows a real low, not the first x to 1 at power-up
    always @(writeStrobeN) begin
        if (writeStrobeN === 1'b1 && wrArmed) mem[memAddr] = lowBusPortIn;
        wrArmed = (writeStrobeN === 1'b0);
    end
endmodule : emb_mem_model

/* File: emb_pkg.sv */
// types of the external memory bus controller
package emb_pkg;

    typedef enum logic {
        EMB_FETCH_CYCLE,
        EMB_DATA_CYCLE
    } emb_cycle_kind_t;

    typedef struct packed {
        logic write;
        logic wide;
        logic [15:0] addr;
        logic [7:0] wdata;
    } emb_data_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oeN;
    } emb_pin_t;

endpackage : emb_pkg

/* File: tb_emb_bus_ctrl.sv */
// self-checking bench of the external memory bus controller
`timescale 1ns/1ps
`define CHECK_EQ(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("unexpected %s: expected %h seen %h", what, exp, got); \
        end \
    end
module tb_emb_bus_ctrl;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic externalCodeSelect = 1'b0;
    logic idleMode = 1'b0;
    logic powerDownMode = 1'b0;
    logic powerCtrlWrEn = 1'b0;
    logic [7:0] powerCtrlWrData = 8'h00;
    logic [15:0] fetchAddr = 16'h1234;
    logic dataReq = 1'b0;
    emb_pkg::emb_data_req_t dataCmd = '0;
    logic [7:0] lowPortReg = 8'hff;
    logic [7:0] upperPortReg = 8'hff;
    logic [7:0] lowBusPortIn, upperAddressPort, fetchData, dataRdata, upperSeen, busSeen;
    emb_pkg::emb_pin_t lowBusPort;
    logic addrLatchStrobe, programFetchStrobeN, writeStrobeN, readStrobeN;
    logic latchQuietBit, fetchValid, dataAck, ackSeen;
    int num_errors = 0;
    int comparisons = 0;
    int aleCnt, fetchCnt, rdCnt, wrCnt;
    emb_bus_ctrl u_emb_bus_ctrl (.sys_clk, .reset, .externalCodeSelect, .idleMode,
        .powerDownMode, .powerCtrlWrEn, .powerCtrlWrData, .fetchAddr, .dataReq, .dataCmd,
        .lowPortReg, .upperPortReg, .lowBusPortIn, .lowBusPort, .upperAddressPort,
        .addrLatchStrobe, .programFetchStrobeN, .writeStrobeN, .readStrobeN,
        .latchQuietBit, .fetchValid, .fetchData, .dataAck, .dataRdata);
    emb_mem_model u_emb_mem_model (.sys_clk, .lowBusPort, .upperAddressPort,
        .addrLatchStrobe, .programFetchStrobeN, .writeStrobeN, .readStrobeN, .lowBusPortIn);
    initial forever #2 sys_clk = ~sys_clk;
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pat
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic wait_clk(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_clk
    // strap is flipped right after capture, so a late change must not count
    task automatic do_reset(input logic strap);
        reset = 1'b1;
        externalCodeSelect = strap;
        wait_clk(8);
        `CHECK_EQ("quiet in reset", 1'b0, latchQuietBit)
        `CHECK_EQ("fetch strobe in reset", 1'b1, programFetchStrobeN)
        reset = 1'b0;
        wait_clk(2);
        externalCodeSelect = !strap;
        wait_clk(12);
    endtask : do_reset
    task automatic observe(input int n);
        logic prevAle;
        logic prevFetch;
        prevAle = addrLatchStrobe;
        prevFetch = programFetchStrobeN;
        aleCnt = 0;
        fetchCnt = 0;
        rdCnt = 0;
        wrCnt = 0;
        ackSeen = 1'b0;
        repeat (n) begin
            @(negedge sys_clk);
            if (addrLatchStrobe === 1'b1 && prevAle === 1'b0) aleCnt++;
            if (programFetchStrobeN === 1'b0 && prevFetch === 1'b1) fetchCnt++;
            if (readStrobeN === 1'b0) rdCnt++;
            if (writeStrobeN === 1'b0) begin
                wrCnt++;
                busSeen = lowBusPort.out;
            end
            if (readStrobeN === 1'b0 || writeStrobeN === 1'b0) upperSeen = upperAddressPort;
            if (fetchValid === 1'b1) `CHECK_EQ("fetch byte", pat(fetchAddr), fetchData)
            if (dataAck === 1'b1) begin
                ackSeen = 1'b1;
                dataReq = 1'b0;
            end
            prevAle = addrLatchStrobe;
            prevFetch = programFetchStrobeN;
        end
    endtask : observe
    task automatic set_quiet(input logic [7:0] d);
        powerCtrlWrEn = 1'b1;
        powerCtrlWrData = d;
        wait_clk(1);
        powerCtrlWrEn = 1'b0;
        wait_clk(1);
        `CHECK_EQ("quiet bit", d[5], latchQuietBit)
    endtask : set_quiet
    // one access inside a 36-clock window; request is dropped on the ack
    task automatic data_access(input logic wr, input logic wide, input logic [15:0] a,
            input logic [7:0] wd, input int expAle);
        dataCmd = '{write: wr, wide: wide, addr: a, wdata: wd};
        dataReq = 1'b1;
        observe(36);
        `CHECK_EQ("data ack", 1'b1, ackSeen)
        `CHECK_EQ("latch pulses in data window", expAle, aleCnt)
        `CHECK_EQ("strobe low cycles", 6, wr ? wrCnt : rdCnt)
    endtask : data_access
    task automatic t_external_code;
        observe(24);
        `CHECK_EQ("latch pulses", 4, aleCnt)
        `CHECK_EQ("fetch strobes", 4, fetchCnt)
        set_quiet(8'h20);
        observe(24);
        `CHECK_EQ("latch pulses quiet ext", 4, aleCnt)
        set_quiet(8'h00);
    endtask : t_external_code
    task automatic t_data_cycles;
        // port register differs from the address byte, so a wide access is told apart
        upperPortReg = 8'h00;
        data_access(1'b0, 1'b1, 16'hffff, 8'h00, 5);
        `CHECK_EQ("fetch strobes with data", 4, fetchCnt)
        `CHECK_EQ("read byte top", pat(16'hffff), dataRdata)
        `CHECK_EQ("upper wide", 8'hff, upperSeen)
        upperPortReg = 8'h3c;
        data_access(1'b1, 1'b0, 16'h0077, 8'hc3, 5);
        `CHECK_EQ("upper narrow", 8'h3c, upperSeen)
        `CHECK_EQ("write byte on bus", 8'hc3, busSeen)
        upperPortReg = 8'ha5;
        data_access(1'b0, 1'b1, 16'h3c77, 8'h00, 5);
        `CHECK_EQ("read back", 8'hc3, dataRdata)
        `CHECK_EQ("upper wide read", 8'h3c, upperSeen)
    endtask : t_data_cycles
    task automatic t_internal_code;
        fetchAddr = 16'h1000;
        lowPortReg = 8'h0f;
        wait_clk(12);
        observe(24);
        `CHECK_EQ("latch pulses internal", 4, aleCnt)
        `CHECK_EQ("fetch strobes internal", 0, fetchCnt)
        `CHECK_EQ("low port enables", 8'h0f, lowBusPort.oeN)
        set_quiet(8'h20);
        observe(24);
        `CHECK_EQ("latch pulses quiet", 0, aleCnt)
        data_access(1'b0, 1'b1, 16'h0042, 8'h00, 1);
        `CHECK_EQ("read byte quiet", pat(16'h0042), dataRdata)
        fetchAddr = 16'h4000;
        wait_clk(12);
        observe(24);
        `CHECK_EQ("latch pulses high addr", 4, aleCnt)
        `CHECK_EQ("fetch strobes high addr", 4, fetchCnt)
        fetchAddr = 16'h1000;
        // let the external slot finish before sleeping, so no fetch is cut short
        wait_clk(12);
        idleMode = 1'b1;
        wait_clk(12);
        observe(12);
        `CHECK_EQ("latch idle", 1'b1, addrLatchStrobe)
        idleMode = 1'b0;
        powerDownMode = 1'b1;
        wait_clk(12);
        `CHECK_EQ("latch power-down", 1'b0, addrLatchStrobe)
        powerDownMode = 1'b0;
        set_quiet(8'h00);
        wait_clk(12);
        observe(24);
        `CHECK_EQ("latch pulses restored", 4, aleCnt)
        // keep the write off a slot's first phase so the pulse in flight completes
        wait_clk(1);
        set_quiet(8'h20);
    endtask : t_internal_code
    initial begin
        do_reset(1'b0);
        t_external_code();
        t_data_cycles();
        do_reset(1'b1);
        t_internal_code();
        do_reset(1'b0);
        test_done();
    end
endmodule : tb_emb_bus_ctrl
